/* File: design/wiper_pkg.sv */
// Constants shared by the dual wiper register bank.
// Assumes a single 25 MHz clock domain and a two-wire bus master outside.
package wiper_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int POT_N = 2;
    localparam int SLOT_N = 4;
    localparam int POS_W = 6;
    localparam int TAPS = 64;
    localparam int SLOT_IDX_W = 3;
    localparam int CLK_MHZ = 25;
    localparam logic [POS_W-1:0] POS_MAX = 6'h3f;
    localparam logic [POS_W-1:0] POS_MIN = 6'h00;
    localparam logic [POS_W-1:0] POS_ONE = 6'h01;
    localparam logic [TAPS-1:0] TAP_ONE = 64'h1;
    // Reset image of the saved setting slots
    localparam logic [POS_W-1:0] SLOT_RST = 6'h20;

    // ************************************************************
    // Address and instruction layout
    // ************************************************************
    // Fixed upper part of the 7-bit slave address, arbitrary value
    localparam logic [2:0] DEV_PREFIX = 3'h2;
    localparam int OP_HI = 7;
    localparam int OP_LO = 4;
    localparam int POT_BIT = 2;
    localparam int SLOT_HI = 1;
    localparam int DIR_BIT = 0;
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_SLOT = 4'hb;
    localparam logic [3:0] OP_WR_SLOT = 4'hc;
    localparam logic [3:0] OP_TO_WIPER = 4'hd;
    localparam logic [3:0] OP_TO_SLOT = 4'he;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_INSTR = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_TX_NEXT
    } bus_state_e;
endpackage

/* File: design/dual_wiper_register_i2c.sv */
// Dual wiper position registers, saved slots and two-wire bus slave.
// Assumes scl and sda come from pins; the master makes the bus clock.
//
// Behaviour
// - Each of two pots has its own 6-bit position register.
// - Four 6-bit saved setting slots per wiper, eight in all.
// - After reset, slot 0 of each pot loads its position register.
// - Exactly one tap per pot is selected, given by its position.
// - 63 elements give 64 taps addressed by the 6-bit code.
// - Four address straps form the address; sixteen devices per bus.
// - Only a matching slave address starts a transfer; else silent.
// - Data line is open drain: pull low or release only.
// - Bus reads and writes reach both positions and all slots.
// - Instructions copy between a position and its own slots.
// - An instruction enters increment/decrement stepping mode.
`timescale 1ns/1ps
module dual_wiper_register_i2c (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Bus pins
    input logic scl_pin,
    input logic sda_pin,
    output logic sda_dat,
    output logic sda_oe_n,
    // Address straps
    input logic addr_strap_bit0,
    input logic addr_strap_bit1,
    input logic addr_strap_bit2,
    input logic addr_strap_bit3,
    // Tap selection, one-hot per pot
    output logic [wiper_pkg::TAPS-1:0] tap_sel0,
    output logic [wiper_pkg::TAPS-1:0] tap_sel1,
    // Mode status
    output logic incdec_mode
);
    import wiper_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic scl_lv_r, sda_lv_r;
    wire scl_nv = (scl_s2 == scl_s3) ? scl_s2 : scl_lv_r;
    wire sda_nv = (sda_s2 == sda_s3) ? sda_s2 : sda_lv_r;
    // Bus clock edges found by the local clock
    wire scl_rise = !scl_lv_r && scl_nv;
    wire scl_fall = scl_lv_r && !scl_nv;
    wire start_ev = scl_lv_r && scl_nv && sda_lv_r && !sda_nv;
    wire stop_ev = scl_lv_r && scl_nv && !sda_lv_r && sda_nv;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            scl_lv_r <= 1'b1;
            sda_lv_r <= 1'b1;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_pin, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_pin, sda_s1, sda_s2};
            scl_lv_r <= scl_nv;
            sda_lv_r <= sda_nv;
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************
    logic [POS_W-1:0] wiper_r [POT_N];
    logic [POS_W-1:0] slot_r [POT_N*SLOT_N];
    logic [TAPS-1:0] tap_r [POT_N];
    logic recall_r;
    logic incdec_r;

    // ************************************************************
    // Bus state
    // ************************************************************
    bus_state_e state_r, state_nxt;
    logic [2:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic rd_r, rd_nxt;
    logic [7:0] instr_r;
    logic oe_n_r, oe_n_nxt;
    logic sda_o_r;

    wire [6:0] my_addr = {DEV_PREFIX, addr_strap_bit3, addr_strap_bit2,
                          addr_strap_bit1, addr_strap_bit0};
    wire [7:0] rx_byte = {shift_r[6:0], sda_nv};
    wire rx_done = (state_r == ST_RX) && scl_rise && (bitcnt_r == BIT_LAST);
    // Address compare against the straps
    wire addr_hit = (rx_byte[7:1] == my_addr);
    wire got_addr = rx_done && (idx_r == IDX_ADDR);
    wire got_instr = rx_done && (idx_r == IDX_INSTR);
    wire got_data = rx_done && (idx_r == IDX_DATA);
    wire [3:0] cur_op = instr_r[OP_HI:OP_LO];
    wire [3:0] new_op = rx_byte[OP_HI:OP_LO];
    wire cur_pot = instr_r[POT_BIT];
    wire new_pot = rx_byte[POT_BIT];
    wire [SLOT_IDX_W-1:0] cur_sel = instr_r[POT_BIT:0];
    wire [SLOT_IDX_W-1:0] new_sel = rx_byte[POT_BIT:0];
    wire [POS_W-1:0] rd_val = (cur_op == OP_RD_SLOT) ?
                              slot_r[cur_sel] : wiper_r[cur_pot];
    wire [7:0] tx_load = {2'h0, rd_val};
    wire step_up = rx_byte[DIR_BIT];
    wire [POS_W-1:0] cur_pos = wiper_r[cur_pot];
    // Saturating step, no wrap
    wire [POS_W-1:0] step_pos = step_up ?
        ((cur_pos == POS_MAX) ? POS_MAX : cur_pos + POS_ONE) :
        ((cur_pos == POS_MIN) ? POS_MIN : cur_pos - POS_ONE);

    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        idx_nxt = idx_r;
        rd_nxt = rd_r;
        oe_n_nxt = oe_n_r;
        if (recall_r) begin
            state_nxt = ST_IDLE;
        end else if (start_ev) begin
            state_nxt = ST_RX;
            bitcnt_nxt = 3'h0;
            idx_nxt = IDX_ADDR;
            oe_n_nxt = 1'b1;
        end else if (stop_ev) begin
            state_nxt = ST_IDLE;
            oe_n_nxt = 1'b1;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_nxt = rx_byte;
                        bitcnt_nxt = bitcnt_r + 3'h1;
                        if (bitcnt_r == BIT_LAST) begin
                            // Stay silent unless addressed
                            if (idx_r == IDX_ADDR && !addr_hit) begin
                                state_nxt = ST_IDLE;
                            end else begin
                                state_nxt = ST_RX_ACK;
                            end
                            if (idx_r == IDX_ADDR) begin
                                rd_nxt = rx_byte[0];
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (oe_n_r) begin
                            oe_n_nxt = 1'b0;
                        end else if (rd_r) begin
                            state_nxt = ST_TX;
                            shift_nxt = tx_load;
                            oe_n_nxt = tx_load[7];
                            bitcnt_nxt = 3'h0;
                        end else begin
                            state_nxt = ST_RX;
                            oe_n_nxt = 1'b1;
                            bitcnt_nxt = 3'h0;
                            if (idx_r != IDX_DATA) begin
                                idx_nxt = idx_r + 2'h1;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_r == BIT_LAST) begin
                            state_nxt = ST_TX_ACK;
                            oe_n_nxt = 1'b1;
                        end else begin
                            bitcnt_nxt = bitcnt_r + 3'h1;
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_n_nxt = shift_r[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        state_nxt = sda_nv ? ST_IDLE : ST_TX_NEXT;
                    end
                end
                ST_TX_NEXT: begin
                    if (scl_fall) begin
                        state_nxt = ST_TX;
                        shift_nxt = tx_load;
                        oe_n_nxt = tx_load[7];
                        bitcnt_nxt = 3'h0;
                    end
                end
                default: begin
                    oe_n_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            bitcnt_r <= 3'h0;
            shift_r <= 8'h00;
            idx_r <= IDX_ADDR;
            rd_r <= 1'b0;
            oe_n_r <= 1'b1;
            sda_o_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            idx_r <= idx_nxt;
            rd_r <= rd_nxt;
            // Only pull low or release
            oe_n_r <= oe_n_nxt;
            sda_o_r <= 1'b0;
        end
    end

    // ************************************************************
    // Register bank updates
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            instr_r <= 8'h00;
            incdec_r <= 1'b0;
            recall_r <= 1'b1;
        end else begin
            recall_r <= 1'b0;
            if (got_instr) begin
                instr_r <= rx_byte;
                // Mode held until another instruction
                incdec_r <= (new_op == OP_INCDEC);
            end
        end
    end

    // Per pot: position register and its own four slots
    genvar p, s;
    generate
        for (p = 0; p < POT_N; p++) begin : g_pot
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    wiper_r[p] <= POS_MIN;
                end else if (recall_r) begin
                    // Recall of the first slot
                    wiper_r[p] <= slot_r[p*SLOT_N];
                end else if (got_instr && new_op == OP_TO_WIPER
                             && new_pot == p) begin
                    wiper_r[p] <= slot_r[new_sel];
                end else if (got_data && cur_pot == p
                             && cur_op == OP_WR_WIPER) begin
                    wiper_r[p] <= rx_byte[POS_W-1:0];
                end else if (got_data && cur_pot == p && incdec_r) begin
                    wiper_r[p] <= step_pos;
                end
            end
            // One-hot tap decode, 64 taps
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    tap_r[p] <= TAP_ONE;
                end else begin
                    tap_r[p] <= TAP_ONE << wiper_r[p];
                end
            end
            for (s = 0; s < SLOT_N; s++) begin : g_slot
                always_ff @(posedge mclk or posedge rst) begin
                    if (rst) begin
                        slot_r[p*SLOT_N+s] <= SLOT_RST;
                    end else if (got_instr && new_op == OP_TO_SLOT
                                 && new_sel == p*SLOT_N+s) begin
                        slot_r[p*SLOT_N+s] <= wiper_r[p];
                    end else if (got_data && cur_op == OP_WR_SLOT
                                 && cur_sel == p*SLOT_N+s) begin
                        slot_r[p*SLOT_N+s] <= rx_byte[POS_W-1:0];
                    end
                end
            end
        end
    endgenerate

    assign sda_dat = sda_o_r;
    assign sda_oe_n = oe_n_r;
    assign tap_sel0 = tap_r[0];
    assign tap_sel1 = tap_r[1];
    assign incdec_mode = incdec_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    wire [POS_W-1:0] w0 = wiper_r[0];
    wire [POS_W-1:0] s0 = slot_r[0];
    wire [POS_W-1:0] new_slot = slot_r[new_sel];
    wire [POS_W-1:0] rx_pos = rx_byte[POS_W-1:0];

    sequence miss_seq;
        got_addr && !addr_hit;
    endsequence
    sequence silent_seq;
        (state_r == ST_IDLE && oe_n_r) [*2];
    endsequence

    a_tap_onehot: assert property (@(posedge mclk) disable iff (rst)
        $onehot(tap_sel0) && $onehot(tap_sel1))
        else $error("tap select not one-hot");
    a_tap_follow: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> tap_sel0 == (TAP_ONE << $past(w0)))
        else $error("tap select does not follow position");
    a_recall_slot: assert property (@(posedge mclk)
        disable iff (rst) $fell(recall_r) |-> w0 == s0)
        else $error("first slot not recalled");
    a_addr_silent: assert property (@(posedge mclk)
        disable iff (rst) miss_seq |=> silent_seq)
        else $error("drove bus without address match");
    a_addr_ack: assert property (@(posedge mclk) disable iff (rst)
        got_addr && addr_hit && !start_ev && !stop_ev
        |=> state_r == ST_RX_ACK)
        else $error("matching address not acknowledged");
    a_open_drain: assert property (@(posedge mclk) disable iff (rst)
        !sda_dat && (sda_oe_n || state_r inside {ST_TX, ST_RX_ACK}))
        else $error("data line driven high or out of turn");
    a_write_pos: assert property (@(posedge mclk) disable iff (rst)
        got_data && cur_op == OP_WR_WIPER && !cur_pot
        |=> w0 == $past(rx_pos))
        else $error("position write lost");
    a_copy_slot: assert property (@(posedge mclk) disable iff (rst)
        got_instr && new_op == OP_TO_WIPER && !new_pot
        |=> w0 == $past(new_slot))
        else $error("slot to position copy lost");
    a_mode_entry: assert property (@(posedge mclk)
        disable iff (rst) got_instr && new_op == OP_INCDEC |=> incdec_mode)
        else $error("step mode not entered");
    a_step_sat: assert property (@(posedge mclk) disable iff (rst)
        got_data && incdec_r && !cur_pot && w0 == POS_MAX && step_up
        |=> w0 == POS_MAX)
        else $error("step wrapped past top");
endmodule

/* File: tb/bus_master_model.sv */
// Two-wire bus master model: start, stop and bit and byte transfers.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/1ps
module bus_master_model (
    // Clock
    input wire logic mclk,
    // Bus
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    // ************************************************************
    // Bus line state, idle high
    // ************************************************************
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Also serves as repeated start from mid-frame
    task automatic start();
        @(posedge mclk);
        sda_pull <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_pull <= 1'b1;
        hold(4);
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic stop();
        sda_pull <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_pull <= 1'b0;
        hold(4);
    endtask

    // Data set while clock low, sampled at the end of the high half
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        hold(2);
        scl <= 1'b1;
        hold(4);
        r = sda_wire;
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the dual wiper register bank.
// Assumes a bus master model on the far side and a pull-up on data.
`timescale 1ns/1ps
module tb_top;
    import wiper_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] strap = 4'h5;
    logic scl, sda_pull, sda_dat, sda_oe_n, incdec_mode;
    logic [TAPS-1:0] tap0, tap1;
    wire sda_wire;
    int miscompares = 0;
    int cmp_count = 0;
    logic quiet = 1'b0;
    logic pulled = 1'b0;

    // ************************************************************
    // Clock, wire and instances
    // ************************************************************
    always #20 mclk = ~mclk;
    // Pull-up: low only while some party pulls it
    assign sda_wire = ~(sda_pull | (sda_oe_n === 1'b0));
    always @(posedge mclk) begin
        if (quiet && sda_oe_n === 1'b0) begin
            pulled <= 1'b1;
        end
    end

    bus_master_model bus_u (.mclk(mclk), .sda_wire(sda_wire), .scl(scl),
        .sda_pull(sda_pull));
    dual_wiper_register_i2c dut_u (.mclk(mclk), .rst(rst), .scl_pin(scl),
        .sda_pin(sda_wire), .sda_dat(sda_dat), .sda_oe_n(sda_oe_n),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]),
        .tap_sel0(tap0), .tap_sel1(tap1), .incdec_mode(incdec_mode));

    // ************************************************************
    // Compare and bus tasks
    // ************************************************************
    task automatic chk_tap(string what, logic [TAPS-1:0] exp,
        logic [TAPS-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] addr(logic rd);
        return {DEV_PREFIX, strap, rd};
    endfunction

    task automatic send(logic [7:0] b);
        logic [7:0] rx;
        logic r;
        bus_u.byte_io(b, rx);
        bus_u.bit_io(1'b1, r);
        chk_byte("ack", 8'h01, {7'h00, ~r});
        chk_byte("sda_dat", 8'h00, {7'h00, sda_dat});
    endtask

    // Instruction then n copies of one data byte
    task automatic wframe(logic [7:0] instr, logic [7:0] d, int n);
        bus_u.start();
        send(addr(1'b0));
        send(instr);
        for (int i = 0; i < n; i++) begin
            send(d);
        end
        bus_u.stop();
    endtask

    task automatic rframe(logic [7:0] instr, logic [5:0] exp);
        logic [7:0] rx;
        logic r;
        wframe(instr, 8'h00, 0);
        bus_u.start();
        send(addr(1'b1));
        bus_u.byte_io(8'hff, rx);
        bus_u.bit_io(1'b1, r);
        bus_u.stop();
        chk_byte("read", {2'b00, exp}, rx);
    endtask

    function automatic logic [TAPS-1:0] tap(logic [5:0] p);
        return TAP_ONE << p;
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_recall();
        chk_tap("tap0", tap(SLOT_RST), tap0);
        chk_tap("tap1", tap(SLOT_RST), tap1);
        chk_byte("mode", 8'h00, {7'h00, incdec_mode});
        rframe({OP_RD_WIPER, 4'h4}, SLOT_RST);
    endtask

    // Top position on pot 1, low value 5 on pot 0, each pot independent
    task automatic t_position();
        wframe({OP_WR_WIPER, 4'h0}, 8'h05, 1);
        wframe({OP_WR_WIPER, 4'h4}, 8'h3f, 1);
        chk_tap("tap0", tap(6'h05), tap0);
        chk_tap("tap1", tap(6'h3f), tap1);
        rframe({OP_RD_WIPER, 4'h0}, 6'h05);
        rframe({OP_RD_WIPER, 4'h4}, 6'h3f);
    endtask

    task automatic t_slots();
        for (int i = 0; i < 8; i++) begin
            wframe({OP_WR_SLOT, 1'b0, 3'(i)}, 8'(7 * i + 3), 1);
        end
        for (int i = 0; i < 8; i++) begin
            rframe({OP_RD_SLOT, 1'b0, 3'(i)}, 6'(7 * i + 3));
        end
        chk_tap("tap0", tap(6'h05), tap0);
    endtask

    task automatic t_copy();
        wframe({OP_TO_SLOT, 4'h7}, 8'h00, 0);
        rframe({OP_RD_SLOT, 4'h7}, 6'h3f);
        wframe({OP_WR_WIPER, 4'h4}, 8'h01, 1);
        chk_tap("tap1", tap(6'h01), tap1);
        wframe({OP_TO_WIPER, 4'h7}, 8'h00, 0);
        chk_tap("tap1", tap(6'h3f), tap1);
        wframe({OP_TO_WIPER, 4'h2}, 8'h00, 0);
        chk_tap("tap0", tap(6'd17), tap0);
    endtask

    // Steps past both ends must stick at the end
    task automatic t_incdec();
        wframe({OP_WR_WIPER, 4'h0}, 8'h01, 1);
        wframe({OP_INCDEC, 4'h0}, 8'h00, 2);
        chk_byte("mode", 8'h01, {7'h00, incdec_mode});
        chk_tap("tap0", tap(POS_MIN), tap0);
        wframe({OP_WR_WIPER, 4'h0}, 8'h3e, 1);
        chk_byte("mode", 8'h00, {7'h00, incdec_mode});
        wframe({OP_INCDEC, 4'h0}, 8'h01, 2);
        chk_tap("tap0", tap(POS_MAX), tap0);
        wframe({OP_INCDEC, 4'h0}, 8'h00, 1);
        chk_tap("tap0", tap(6'h3e), tap0);
        chk_tap("tap1", tap(6'h3f), tap1);
    endtask

    // Other strap pattern: no answer, then the straps are moved to 4'ha
    task automatic t_foreign();
        logic [7:0] rx;
        logic r;
        quiet <= 1'b1;
        bus_u.start();
        bus_u.byte_io({DEV_PREFIX, strap ^ 4'h1, 1'b0}, rx);
        bus_u.bit_io(1'b1, r);
        chk_byte("nack", 8'h01, {7'h00, r});
        bus_u.byte_io({OP_WR_WIPER, 4'h0}, rx);
        bus_u.bit_io(1'b1, r);
        bus_u.byte_io(8'h09, rx);
        bus_u.bit_io(1'b1, r);
        bus_u.stop();
        quiet <= 1'b0;
        chk_byte("pulled", 8'h00, {7'h00, pulled});
        chk_tap("tap0", tap(6'h3e), tap0);
        strap <= 4'ha;
        bus_u.hold(2);
        rframe({OP_RD_WIPER, 4'h0}, 6'h3e);
    endtask

    // Two-byte read: master ack continues, nack ends
    task automatic t_burst();
        logic [7:0] rx;
        logic r;
        wframe({OP_RD_SLOT, 4'h7}, 8'h00, 0);
        bus_u.start();
        send(addr(1'b1));
        for (int i = 0; i < 2; i++) begin
            bus_u.byte_io(8'hff, rx);
            bus_u.bit_io(i == 1, r);
            chk_byte("burst", 8'h3f, rx);
        end
        bus_u.stop();
    endtask

    // ************************************************************
    // Run
    // ************************************************************
    task automatic summarize();
        $display("checks %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_recall();
        t_position();
        t_slots();
        t_copy();
        t_incdec();
        t_foreign();
        t_burst();
        summarize();
    end

    // Hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        summarize();
    end
endmodule
